/* rtl/far_pkg.sv */
// package of constants and types for the fault alarm and reset block
package far_pkg;
  localparam int unsigned FAR_NUM_SRC        = 11;
  // alarm source bit positions
  localparam int unsigned FAR_SRC_RAM        = 0;
  localparam int unsigned FAR_SRC_NVM        = 1;
  localparam int unsigned FAR_SRC_CACHE      = 2;
  localparam int unsigned FAR_SRC_PROBE      = 3;
  localparam int unsigned FAR_SRC_WDT0       = 4;
  localparam int unsigned FAR_SRC_WDT1       = 5;
  localparam int unsigned FAR_SRC_FLOW       = 6;
  localparam int unsigned FAR_SRC_CRYPTO     = 7;
  localparam int unsigned FAR_SRC_ENV        = 8;
  localparam int unsigned FAR_SRC_BOOT       = 9;
  localparam int unsigned FAR_SRC_SELFTEST   = 10;
  // environmental sensor bit positions
  localparam int unsigned FAR_ENV_TEMP       = 0;
  localparam int unsigned FAR_ENV_VOLT       = 1;
  localparam int unsigned FAR_ENV_FREQ       = 2;
  localparam int unsigned FAR_ENV_LIGHT      = 3;
  localparam int unsigned FAR_NUM_ENV        = 4;
  // timing
  localparam int unsigned FAR_CLK_MHZ        = 100;
  localparam int unsigned FAR_RST_HOLD_NS    = 200;
  localparam int unsigned FAR_RST_HOLD_CYC   = (FAR_RST_HOLD_NS * FAR_CLK_MHZ + 999) / 1000;
  localparam int unsigned FAR_WDT_DEF_LIMIT  = 1000;
  localparam logic [31:0] FAR_SIG_SEED       = 32'h0000_0001;
  localparam logic [31:0] FAR_SIG_POLY       = 32'h04c1_1db7;

  typedef enum logic [2:0] {
    FAR_ST_RESET   = 3'h0,
    FAR_ST_BOOT    = 3'h1,
    FAR_ST_RUN     = 3'h2,
    FAR_ST_SECURE  = 3'h3,
    FAR_ST_RST_SEQ = 3'h4
  } far_state_t;

  typedef enum logic [1:0] {
    FAR_TST_IDLE  = 2'h0,
    FAR_TST_FORCE = 2'h1,
    FAR_TST_CHECK = 2'h2
  } far_test_t;
endpackage

/* rtl/far_top.sv */
// fault and attack alarm collector with security reset sequencer
//
// Behaviour
// - any ram bit error seen on a read raises the security alarm.
// - single-bit nvm errors are corrected silently; uncorrectable ones alarm.
// - cache parity is checked on every hit so modified data is caught.
// - a probing or manipulation detector halts processing and enters security reset.
// - two independent watchdogs, each restarted by its own checkpoint.
// - optional running hash over executed instructions, compared at each check point.
// - a signature mismatch means an illegal path and raises the alarm.
// - crypto unit backward-recompute mismatch raises the alarm.
// - start-up applies configuration and runs subsystem tests before releasing the cpu.
// - software self-test forces alarm lines and reports whether each one responded.
// - temperature, voltage, frequency or backside light violation enters secure state.
// - entering the secure state starts the internal reset sequence.
`timescale 1ns/1ps
module far_top #(
  parameter int unsigned WDT_LIMIT = far_pkg::FAR_WDT_DEF_LIMIT,
  parameter int unsigned NVM_DW    = 32,
  parameter int unsigned CACHE_DW  = 32
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  // ram error detection
  input  wire logic                                i_ram_rd,
  input  wire logic                                i_ram_err,
  // nvm ecc read path
  input  wire logic                                i_nvm_rd,
  input  wire logic [NVM_DW-1:0]                   i_nvm_data,
  input  wire logic [$clog2(NVM_DW+1)-1:0]         i_nvm_syn_pos,
  input  wire logic                                i_nvm_single,
  input  wire logic                                i_nvm_multi,
  output logic      [NVM_DW-1:0]                   o_nvm_data,
  output logic                                     o_nvm_valid,
  // cache parity
  input  wire logic                                i_cache_rd,
  input  wire logic [CACHE_DW-1:0]                 i_cache_data,
  input  wire logic                                i_cache_par,
  // physical detectors and sensors (asynchronous pins)
  input  wire logic                                i_probe_det,
  input  wire logic [far_pkg::FAR_NUM_ENV-1:0]     i_env_det,
  // watchdogs
  input  wire logic [1:0]                          i_wdt_en,
  input  wire logic [1:0]                          i_wdt_chkpt,
  // instruction flow signature
  input  wire logic                                i_instruction_flow_signature_en,
  input  wire logic                                i_instr_valid,
  input  wire logic [31:0]                         i_instr_word,
  input  wire logic                                i_sig_check,
  input  wire logic [31:0]                         i_sig_expected,
  // symmetric crypto unit backward check
  input  wire logic                                i_symmetric_crypto_unit_done,
  input  wire logic [127:0]                        i_symmetric_crypto_unit_in,
  input  wire logic [127:0]                        i_symmetric_crypto_unit_back,
  // start-up
  input  wire logic                                i_boot_cfg_done,
  input  wire logic                                i_boot_test_done,
  input  wire logic                                i_boot_test_fail,
  // user self-test
  input  wire logic                                i_user_alarm_self_test_start,
  input  wire logic [far_pkg::FAR_NUM_SRC-1:0]     i_user_alarm_self_test_sel,
  output logic                                     o_user_alarm_self_test_busy,
  output logic                                     o_user_alarm_self_test_done,
  output logic [far_pkg::FAR_NUM_SRC-1:0]          o_user_alarm_self_test_pass,
  // results
  output logic                                     o_cpu_run,
  output logic                                     o_cpu_halt,
  output logic                                     o_security_alarm,
  output logic [far_pkg::FAR_NUM_SRC-1:0]          o_alarm_cause,
  output logic                                     o_reset_req,
  output logic                                     o_int_reset
);
  import far_pkg::*;

  // refuse sizes that the watchdog compare, the ecc index or the parity tree cannot serve
  if (WDT_LIMIT < 1) begin : g_bad_limit
    $error("far_top: watchdog limit must be at least one");
  end
  if (NVM_DW < 2) begin : g_bad_nvm
    $error("far_top: nvm word too narrow");
  end
  if (CACHE_DW < 1) begin : g_bad_cache
    $error("far_top: cache word too narrow");
  end

  localparam int unsigned HOLD_W = $clog2(FAR_RST_HOLD_CYC + 1);

  function automatic logic agree3(input logic [2:0] s);
    return s[1] & s[2];
  endfunction

  // both secure states hold the cpu and stop the watchdogs
  function automatic logic in_secure(input far_state_t s);
    return (s == FAR_ST_SECURE) || (s == FAR_ST_RST_SEQ);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: an alarm counts while stages two and three are both high
  logic [2:0] probe_sync_r;
  logic [2:0] env_sync_r [FAR_NUM_ENV];
  logic       probe_hit;
  logic [FAR_NUM_ENV-1:0] env_hit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) probe_sync_r <= 3'h0;
    else       probe_sync_r <= {probe_sync_r[1:0], i_probe_det};
  end
  assign probe_hit = agree3(probe_sync_r);

  genvar g;
  generate
    for (g = 0; g < FAR_NUM_ENV; g++) begin : g_env
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) env_sync_r[g] <= 3'h0;
        else       env_sync_r[g] <= {env_sync_r[g][1:0], i_env_det[g]};
      end
      assign env_hit[g] = agree3(env_sync_r[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // watchdogs
  far_state_t st_r;
  far_wdt_if  wdt_bus [2] ();
  logic [1:0] wdt_exp;
  generate
    for (g = 0; g < 2; g++) begin : g_wdt
      // the secure entry stops both counters so a stale expiry cannot pin the reset on
      assign wdt_bus[g].enable     = i_wdt_en[g] & ~in_secure(st_r);
      assign wdt_bus[g].limit      = 32'(WDT_LIMIT);
      assign wdt_bus[g].checkpoint = i_wdt_chkpt[g];
      assign wdt_exp[g]            = wdt_bus[g].expired;
      far_wdt u_wdt (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .w     (wdt_bus[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // nvm ecc: flip the flagged bit on a single error
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_nvm_data  <= '0;
      o_nvm_valid <= 1'b0;
    end else begin
      // an uncorrectable word is withheld; only the alarm path reports it
      o_nvm_valid <= i_nvm_rd & ~i_nvm_multi;
      if (i_nvm_rd && i_nvm_single && i_nvm_syn_pos < NVM_DW)
        o_nvm_data <= i_nvm_data ^ (NVM_DW'(1) << i_nvm_syn_pos);
      else if (i_nvm_rd)
        o_nvm_data <= i_nvm_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction flow signature: lfsr-style hash of every executed word
  logic [31:0] sig_r;
  logic        sig_bad;
  // switching the checker off reseeds it, so a re-enable starts from a known hash

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sig_r <= FAR_SIG_SEED;
    end else if (!i_instruction_flow_signature_en) begin
      sig_r <= FAR_SIG_SEED;
    end else if (i_instr_valid) begin
      sig_r <= ({sig_r[30:0], 1'b0} ^ (sig_r[31] ? FAR_SIG_POLY : 32'h0)) ^ i_instr_word;
    end
  end
  // check is against the hash of instructions before the check cycle
  assign sig_bad = i_instruction_flow_signature_en & i_sig_check & (sig_r != i_sig_expected);

  ////////////////////////////////////////////////////////////////////////////
  // self-test: a selected line is forced for one cycle and must be seen
  far_test_t                tst_st_r;
  logic [FAR_NUM_SRC-1:0]   tst_sel_r;
  logic [FAR_NUM_SRC-1:0]   tst_force;
  logic [FAR_NUM_SRC-1:0]   raw_src;
  logic [FAR_NUM_SRC-1:0]   seen_src;
  logic                     live_alarm;

  assign tst_force = (tst_st_r == FAR_TST_FORCE) ? tst_sel_r : '0;

  always_comb begin
    raw_src                   = '0;
    raw_src[FAR_SRC_RAM]      = i_ram_rd & i_ram_err;
    raw_src[FAR_SRC_NVM]      = i_nvm_rd & i_nvm_multi;
    // even parity: the stored bit equals the xor of the word
    raw_src[FAR_SRC_CACHE]    = i_cache_rd & ((^i_cache_data) != i_cache_par);
    raw_src[FAR_SRC_PROBE]    = probe_hit;
    raw_src[FAR_SRC_WDT0]     = wdt_exp[0];
    raw_src[FAR_SRC_WDT1]     = wdt_exp[1];
    raw_src[FAR_SRC_FLOW]     = sig_bad;
    raw_src[FAR_SRC_CRYPTO]   = i_symmetric_crypto_unit_done &
                                (i_symmetric_crypto_unit_in != i_symmetric_crypto_unit_back);
    raw_src[FAR_SRC_ENV]      = |env_hit;
    raw_src[FAR_SRC_BOOT]     = (st_r == FAR_ST_BOOT) & i_boot_test_fail;
    raw_src[FAR_SRC_SELFTEST] = 1'b0;
    seen_src = raw_src | tst_force;
  end

  // forced lines are observed but kept off the reset path
  assign live_alarm = |raw_src;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tst_st_r                    <= FAR_TST_IDLE;
      tst_sel_r                   <= '0;
      o_user_alarm_self_test_done <= 1'b0;
      o_user_alarm_self_test_pass <= '0;
    end else begin
      o_user_alarm_self_test_done <= 1'b0;
      unique case (tst_st_r)
        FAR_TST_IDLE: begin
          // refused outside run so a test cannot mask a start-up fault
          if (i_user_alarm_self_test_start && st_r == FAR_ST_RUN) begin
            tst_sel_r <= i_user_alarm_self_test_sel;
            tst_st_r  <= FAR_TST_FORCE;
          end
        end
        FAR_TST_FORCE: begin
          o_user_alarm_self_test_pass <= seen_src & tst_sel_r;
          tst_st_r                    <= FAR_TST_CHECK;
        end
        FAR_TST_CHECK: begin
          o_user_alarm_self_test_done <= 1'b1;
          tst_st_r                    <= FAR_TST_IDLE;
        end
        default: tst_st_r <= FAR_TST_IDLE;
      endcase
    end
  end
  assign o_user_alarm_self_test_busy = (tst_st_r != FAR_TST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // sticky cause and held reset request: a one-cycle alarm is never lost
  logic [HOLD_W-1:0] hold_r;

  // cause bits survive the internal reset so software can read why it happened
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alarm_cause <= '0;
    end else begin
      o_alarm_cause <= o_alarm_cause | raw_src;
    end
  end

  // set wins over clear so an alarm in the clearing cycle is kept
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_req <= 1'b0;
    end else if (live_alarm) begin
      o_reset_req <= 1'b1;
    end else if (st_r == FAR_ST_RST_SEQ) begin
      o_reset_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: boot, run, secure halt, internal reset pulse, back to boot
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= FAR_ST_RESET;
      hold_r <= '0;
    end else begin
      unique case (st_r)
        FAR_ST_RESET: st_r <= FAR_ST_BOOT;
        FAR_ST_BOOT: begin
          if (live_alarm)
            st_r <= FAR_ST_SECURE;
          else if (i_boot_cfg_done && i_boot_test_done)
            st_r <= FAR_ST_RUN;
        end
        FAR_ST_RUN: begin
          if (live_alarm || o_reset_req)
            st_r <= FAR_ST_SECURE;
        end
        FAR_ST_SECURE: begin
          st_r   <= FAR_ST_RST_SEQ;
          hold_r <= HOLD_W'(FAR_RST_HOLD_CYC);
        end
        FAR_ST_RST_SEQ: begin
          // a source still live at the end of the hold stretches the reset
          if (hold_r > HOLD_W'(1))
            hold_r <= hold_r - HOLD_W'(1);
          else if (!live_alarm)
            st_r <= FAR_ST_BOOT;
        end
        default: st_r <= FAR_ST_RESET;
      endcase
    end
  end

  // halt is immediate on the alarm cycle, not one state later
  assign o_cpu_halt       = live_alarm | in_secure(st_r);
  assign o_cpu_run        = (st_r == FAR_ST_RUN) & ~o_cpu_halt;
  assign o_security_alarm = live_alarm | o_reset_req;
  assign o_int_reset      = (st_r == FAR_ST_RST_SEQ);
endmodule

/* rtl/far_wdt.sv */
// program flow watchdog with checkpoint restart
`timescale 1ns/1ps
module far_wdt (
  input  wire logic i_clk,
  input  wire logic i_rst,
  far_wdt_if.wdt    w
);
  import far_pkg::*;

  logic [31:0] count_r;
  logic        expired_r;

  ////////////////////////////////////////////////////////////////////////////
  // checkpoint before the limit restarts; reaching the limit is a flow fault
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_r   <= 32'h0;
      expired_r <= 1'b0;
    end else if (!w.enable) begin
      // a stopped counter drops its expiry so the secure entry can finish
      count_r   <= 32'h0;
      expired_r <= 1'b0;
    end else if (w.checkpoint) begin
      count_r   <= 32'h0;
    end else if (count_r >= w.limit) begin
      expired_r <= 1'b1;
    end else begin
      count_r   <= count_r + 32'h1;
    end
  end

  assign w.count   = count_r;
  assign w.expired = expired_r;
endmodule

/* rtl/far_wdt_if.sv */
// carrier between the top and each watchdog timer
`timescale 1ns/1ps
interface far_wdt_if;
  logic        enable;
  logic [31:0] limit;
  logic        checkpoint;
  logic [31:0] count;
  logic        expired;
  modport ctrl (output enable, output limit, output checkpoint, input count, input expired);
  modport wdt  (input enable, input limit, input checkpoint, output count, output expired);
endinterface

/* testbench/far_checker.sv */
// port assertions for the fault alarm and reset block
`timescale 1ns/1ps
module far_checker
  import far_pkg::*;
(
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   i_ram_rd,
  input wire logic                   i_ram_err,
  input wire logic                   i_nvm_rd,
  input wire logic                   i_nvm_multi,
  input wire logic                   i_probe_det,
  input wire logic                   o_nvm_valid,
  input wire logic                   o_user_alarm_self_test_busy,
  input wire logic                   o_user_alarm_self_test_done,
  input wire logic                   o_cpu_run,
  input wire logic                   o_cpu_halt,
  input wire logic                   o_security_alarm,
  input wire logic [FAR_NUM_SRC-1:0] o_alarm_cause,
  input wire logic                   o_reset_req,
  input wire logic                   o_int_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ram;
    i_ram_rd && i_ram_err;
  endsequence
  // pin needs the full synchroniser depth before it counts
  sequence s_probe;
    i_probe_det [*4];
  endsequence
  sequence s_hold;
    o_int_reset [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RAM_HALT: assert property (s_ram |-> o_cpu_halt && o_security_alarm)
    else $error("ram error did not halt");
  AST_RAM_CAUSE: assert property (s_ram |=> o_alarm_cause[FAR_SRC_RAM])
    else $error("ram cause not recorded");
  AST_NVM_OK: assert property (i_nvm_rd && !i_nvm_multi |=> o_nvm_valid)
    else $error("nvm read not answered");
  AST_NVM_BAD: assert property (i_nvm_rd && i_nvm_multi |=> !o_nvm_valid && o_alarm_cause[FAR_SRC_NVM])
    else $error("bad nvm word passed");
  AST_PROBE: assert property (s_probe |-> o_cpu_halt)
    else $error("probe did not halt");
  AST_SELFTEST: assert property ($rose(o_user_alarm_self_test_busy) |-> ##2 o_user_alarm_self_test_done ##1 !o_user_alarm_self_test_done)
    else $error("self test done pulse wrong");
  AST_SEC_RESET: assert property ($past(o_cpu_run) ##0 s_ram |-> ##2 o_int_reset)
    else $error("internal reset late");
  AST_INT_HOLD: assert property ($rose(o_int_reset) |-> s_hold)
    else $error("internal reset too short");
  AST_REQ_SET: assert property (s_ram |=> o_reset_req)
    else $error("reset request missing");
  AST_REQ_HOLD: assert property ($fell(o_reset_req) |-> $past(o_int_reset))
    else $error("reset request dropped early");
endmodule
bind far_top far_checker far_checker_inst (.i_clk, .i_rst, .i_ram_rd, .i_ram_err, .i_nvm_rd, .i_nvm_multi,
  .i_probe_det, .o_nvm_valid, .o_user_alarm_self_test_busy, .o_user_alarm_self_test_done, .o_cpu_run,
  .o_cpu_halt, .o_security_alarm, .o_alarm_cause, .o_reset_req, .o_int_reset);

/* testbench/far_top_tb.sv */
// self-checking bench for the fault alarm and reset block
`timescale 1ns/1ps
module far_top_tb;
  import far_pkg::*;
  logic         i_clk = '0, i_rst = '1, i_ram_rd = '0, i_ram_err = '0, i_nvm_rd = '0;
  logic         i_nvm_single = '0, i_nvm_multi = '0, i_cache_rd = '0, i_cache_par = '0, i_probe_det = '0;
  logic         i_instruction_flow_signature_en = '0, i_instr_valid = '0, i_sig_check = '0;
  logic         i_symmetric_crypto_unit_done = '0, i_boot_cfg_done = '0, i_boot_test_done = '0;
  logic         i_boot_test_fail = '0, i_user_alarm_self_test_start = '0;
  logic [31:0]  i_nvm_data = '0, i_cache_data = '0, i_instr_word = '0, i_sig_expected = '0, o_nvm_data;
  logic [5:0]   i_nvm_syn_pos = '0;
  logic [3:0]   i_env_det = '0;
  logic [1:0]   i_wdt_en = '0, i_wdt_chkpt = '0;
  logic [127:0] i_symmetric_crypto_unit_in = '0, i_symmetric_crypto_unit_back = '0;
  logic [10:0]  i_user_alarm_self_test_sel = '0, o_user_alarm_self_test_pass, o_alarm_cause;
  logic         o_nvm_valid, o_user_alarm_self_test_busy, o_user_alarm_self_test_done, o_cpu_run;
  logic         o_cpu_halt, o_security_alarm, o_reset_req, o_int_reset;
  int           err_total = 0, checks = 0;

  always #5 i_clk = ~i_clk;

  // short watchdog limit keeps the expiry scenarios brief
  far_top #(.WDT_LIMIT(10)) far_top_inst (.i_clk, .i_rst, .i_ram_rd, .i_ram_err, .i_nvm_rd, .i_nvm_data,
    .i_nvm_syn_pos, .i_nvm_single, .i_nvm_multi, .o_nvm_data, .o_nvm_valid, .i_cache_rd, .i_cache_data,
    .i_cache_par, .i_probe_det, .i_env_det, .i_wdt_en, .i_wdt_chkpt, .i_instruction_flow_signature_en,
    .i_instr_valid, .i_instr_word, .i_sig_check, .i_sig_expected, .i_symmetric_crypto_unit_done,
    .i_symmetric_crypto_unit_in, .i_symmetric_crypto_unit_back, .i_boot_cfg_done, .i_boot_test_done,
    .i_boot_test_fail, .i_user_alarm_self_test_start, .i_user_alarm_self_test_sel,
    .o_user_alarm_self_test_busy, .o_user_alarm_self_test_done, .o_user_alarm_self_test_pass, .o_cpu_run,
    .o_cpu_halt, .o_security_alarm, .o_alarm_cause, .o_reset_req, .o_int_reset);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic idle;
    {i_ram_rd, i_ram_err, i_nvm_rd, i_nvm_single, i_nvm_multi, i_cache_rd, i_cache_par, i_probe_det} <= '0;
    {i_env_det, i_wdt_en, i_wdt_chkpt, i_instr_valid, i_sig_check, i_symmetric_crypto_unit_done} <= '0;
    {i_user_alarm_self_test_start, i_boot_test_fail, i_instruction_flow_signature_en} <= '0;
  endtask

  task automatic rst_boot;
    @(posedge i_clk);
    idle();
    i_rst <= 1;
    i_boot_cfg_done <= 0;
    i_boot_test_done <= 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 0;
    repeat (2) @(posedge i_clk);
    #1 check("run_early", o_cpu_run, 0);
    @(posedge i_clk);
    i_boot_cfg_done <= 1;
    i_boot_test_done <= 1;
    for (int k = 0; k < 10 && o_cpu_run !== 1'b1; k++) @(posedge i_clk);
    #1 check("run", o_cpu_run, 1);
  endtask

  // a pin alarm stays live through the synchroniser, so only a floor on the hold
  task automatic expect_alarm(input int idx, input bit exact);
    int n;
    n = 0;
    #1;
    for (int k = 0; k < 30 && o_reset_req !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    check("reset_req", o_reset_req, 1);
    check("cause", o_alarm_cause, 32'h1 << idx);
    @(posedge i_clk);
    idle();
    #1;
    while (o_int_reset === 1'b1 && n < 100) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("hold", n >= FAR_RST_HOLD_CYC - 1 && (!exact || n <= FAR_RST_HOLD_CYC + 1), 1);
    rst_boot();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ram;
    @(posedge i_clk);
    i_ram_rd <= 1;
    #1 check("ram_clean", o_security_alarm, 0);
    @(posedge i_clk);
    i_ram_err <= 1;
    #1 check("ram_halt", o_cpu_halt, 1);
    @(posedge i_clk);
    idle();
    expect_alarm(FAR_SRC_RAM, 1);
  endtask

  task automatic t_nvm;
    @(posedge i_clk);
    {i_nvm_rd, i_nvm_single, i_nvm_data, i_nvm_syn_pos} <= {2'h3, 32'h1234_5678, 6'h05};
    @(posedge i_clk);
    i_nvm_rd <= 0;
    #1 check("nvm_valid", o_nvm_valid, 1);
    check("nvm_fix", o_nvm_data, 32'h1234_5658);
    @(posedge i_clk);
    {i_nvm_rd, i_nvm_multi} <= 2'h3;
    @(posedge i_clk);
    idle();
    expect_alarm(FAR_SRC_NVM, 1);
  endtask

  task automatic t_cache;
    @(posedge i_clk);
    {i_cache_rd, i_cache_par, i_cache_data} <= {2'h3, 32'h0000_0007};
    @(posedge i_clk);
    i_cache_par <= 0;
    @(posedge i_clk);
    idle();
    expect_alarm(FAR_SRC_CACHE, 1);
  endtask

  task automatic t_pin(input bit probe, input int b);
    @(posedge i_clk);
    if (probe)
      i_probe_det <= 1;
    else
      i_env_det <= 4'h1 << b;
    repeat (5) @(posedge i_clk);
    #1 check("pin_halt", o_cpu_halt, 1);
    expect_alarm(probe ? FAR_SRC_PROBE : FAR_SRC_ENV, 0);
  endtask

  task automatic t_wdt(input int w);
    @(posedge i_clk);
    i_wdt_en[w] <= 1;
    repeat (4) begin
      repeat (8) @(posedge i_clk);
      i_wdt_chkpt[w] <= 1;
      @(posedge i_clk);
      i_wdt_chkpt[w] <= 0;
    end
    repeat (9) @(posedge i_clk);
    #1 check("wdt_early", o_reset_req, 0);
    expect_alarm(FAR_SRC_WDT0 + w, 1);
  endtask

  task automatic t_flow;
    @(posedge i_clk);
    {i_instr_valid, i_instr_word, i_sig_expected} <= {1'h1, 32'h0000_a5a5, 32'h0bad_0bad};
    @(posedge i_clk);
    i_sig_check <= 1;
    @(posedge i_clk);
    i_sig_check <= 0;
    repeat (3) @(posedge i_clk);
    #1 check("flow_off", o_reset_req, 0);
    @(posedge i_clk);
    {i_instr_valid, i_sig_expected} <= {1'h0, FAR_SIG_SEED};
    i_instruction_flow_signature_en <= 1;
    i_sig_check <= 1;
    @(posedge i_clk);
    {i_instr_valid, i_sig_expected} <= {1'h1, 32'h0bad_0bad};
    i_sig_check <= 0;
    #1 check("flow_match", o_reset_req, 0);
    @(posedge i_clk);
    i_sig_check <= 1;
    @(posedge i_clk);
    idle();
    expect_alarm(FAR_SRC_FLOW, 1);
  endtask

  task automatic t_crypto;
    @(posedge i_clk);
    i_symmetric_crypto_unit_done <= 1;
    i_symmetric_crypto_unit_in <= 128'h5a;
    i_symmetric_crypto_unit_back <= 128'h5a;
    @(posedge i_clk);
    i_symmetric_crypto_unit_back <= 128'h5b;
    @(posedge i_clk);
    idle();
    expect_alarm(FAR_SRC_CRYPTO, 1);
  endtask

  task automatic t_self;
    @(posedge i_clk);
    i_user_alarm_self_test_start <= 1;
    i_user_alarm_self_test_sel <= 11'h0ff;
    @(posedge i_clk);
    i_user_alarm_self_test_start <= 0;
    #1 check("st_busy", o_user_alarm_self_test_busy, 1);
    repeat (2) @(posedge i_clk);
    #1 check("st_done", o_user_alarm_self_test_done, 1);
    check("st_pass", o_user_alarm_self_test_pass, 11'h0ff);
    check("st_noreset", {o_reset_req, o_alarm_cause}, 0);
  endtask

  task automatic t_bootfail;
    @(posedge i_clk);
    i_rst <= 1;
    i_boot_test_done <= 0;
    @(posedge i_clk);
    i_rst <= 0;
    i_boot_test_fail <= 1;
    repeat (4) @(posedge i_clk);
    #1 check("boot_cause", o_alarm_cause[FAR_SRC_BOOT], 1);
    check("boot_run", o_cpu_run, 0);
    rst_boot();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_boot();
    t_ram();
    t_nvm();
    t_cache();
    t_pin(1, 0);
    for (int b = 0; b < FAR_NUM_ENV; b++) t_pin(0, b);
    t_wdt(0);
    t_wdt(1);
    t_flow();
    t_crypto();
    t_self();
    t_bootfail();
    test_done();
  end

  // whole run is well under a thousand cycles
  initial begin
    #400us;
    err_total++;
    test_done();
  end
endmodule
